// [xrs_host.sv]
// flash controller end: xip exit bursts, rescue sequence, reset pin, waits
//
// Behaviour
// [RULE1] quad exit: seven clocks, io0 high
// [RULE2] dual exit: thirteen clocks, io0 high
// [RULE3] extended exit: twenty-five clocks, io0 high
// [RULE4] exit leaves xip, program/erase untouched
// [RULE5] reset pin pulse restores power-on state; xrs_dev keeps the lock bits through a pin reset
// [RULE6] below threshold device ignores everything
// [RULE7] power-up phase: only status reads accepted
// [RULE8] after power-up latches and locks cleared
// [RULE9] wait 150 us after supply before access
// [RULE10] chip select high 50 ns between bursts
// [RULE11] rescue one: bursts of 7, 13, 25
// [RULE12] rescue two: all-ones byte, 8 clocks
// [RULE13] after rescue: extended protocol, no xip
// [RULE14] redo nonvolatile config write after rescue
// [RULE15] reset pin low at least 50 ns
// [RULE16] short recovery 40 ns after reset
// [RULE17] array operations: 30 us recovery
// [RULE18] long operations: wait their own duration
// [RULE19] confirmation sampled in first dummy clock
// [RULE20] leaving xip sets configuration bit 3
// [RULE21] burst length from protocol, else all three
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module xrs_host
	import xrs_pkg::*;
#(
	parameter int HALF_PERIOD = SCLK_HALF_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	xrs_link_if.host link
);
	import xrs_pkg::*;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_PWR = 6'b000010,
		ST_BURST = 6'b000100,
		ST_GAP = 6'b001000,
		ST_RLOW = 6'b010000,
		ST_RWAIT = 6'b100000
	} xrs_host_st_t;
	typedef struct packed {
		xrs_host_st_t st;
		logic [2:0] op;
		xrs_proto_t proto;
		logic [1:0] rec_class;
		logic [31:0] long_wait;
		logic ready;
		logic nv_redo;
		logic [1:0] bidx;
		logic [1:0] blast;
		logic [5:0] ccnt;
		logic [7:0] div;
		logic [31:0] cnt;
		logic cs_n;
		logic sclk;
		logic rst_n;
		logic drive;
		logic [31:0] rdata;
		logic rdy;
		logic err;
	} xrs_host_state_t;
	localparam xrs_host_state_t HOST_RESET = '{st: ST_IDLE, op: 3'h0, proto: XRS_PROTO_UNKNOWN,
		rec_class: REC_SHORT, long_wait: LONG_WAIT_RESET, ready: 1'b0, nv_redo: 1'b0,
		bidx: 2'h0, blast: 2'h0, ccnt: 6'h00, div: 8'h00, cnt: 32'h0, cs_n: 1'b1,
		sclk: 1'b0, rst_n: 1'b1, drive: 1'b0, rdata: 32'h0, rdy: 1'b0, err: 1'b0};
	xrs_host_state_t s_reg;
	xrs_host_state_t s_next;
	logic wr_take;
	logic setup;
	logic [31:0] rec_target;
	assign setup = psel && !penable;
	assign wr_take = psel && penable && pwrite && s_reg.rdy;

	// recovery after a reset pulse depends on what the device was doing
	always_comb
	begin
		rec_target = 32'(RESET_RECOVERY_CYC); // [RULE16]
		if (s_reg.rec_class == REC_ARRAY)
			rec_target = 32'(ARRAY_RECOVERY_CYC); // [RULE17]
		else if (s_reg.rec_class == REC_LONG)
			rec_target = s_reg.long_wait; // [RULE18]
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		s_next = s_reg;
		// pready stays high from the first edge: zero-wait slave
		s_next.rdy = 1'b1;
		if (setup)
		begin
			s_next.err = 1'b0;
			s_next.rdata = 32'h0;
			case (paddr)
				CTRL_OFFSET: s_next.rdata = {24'h0, s_reg.rec_class, s_reg.proto, 1'b0, s_reg.op};
				STATUS_OFFSET: s_next.rdata = {29'h0, s_reg.nv_redo, s_reg.ready,
					s_reg.st != ST_IDLE};
				LONG_WAIT_OFFSET: s_next.rdata = s_reg.long_wait;
				default: s_next.err = 1'b1;
			endcase
		end
		if (wr_take && paddr == STATUS_OFFSET && pwdata[2])
			s_next.nv_redo = 1'b0;
		if (wr_take && paddr == LONG_WAIT_OFFSET)
			s_next.long_wait = pwdata;
		if (wr_take && paddr == CTRL_OFFSET && s_reg.st == ST_IDLE)
		begin
			// commands written while busy are dropped
			s_next.op = pwdata[2:0];
			s_next.proto = xrs_proto_t'(pwdata[5:4]);
			s_next.rec_class = pwdata[7:6];
			s_next.cnt = 32'h0;
			s_next.ccnt = 6'h00;
			s_next.div = 8'h00;
			case (pwdata[2:0])
				OP_EXIT_XIP:
				begin
					s_next.st = ST_BURST;
					s_next.cs_n = 1'b0;
					s_next.drive = 1'b1;
					case (xrs_proto_t'(pwdata[5:4])) // [RULE21]
						XRS_PROTO_QUAD: s_next.bidx = 2'h0; // [RULE1]
						XRS_PROTO_DUAL: s_next.bidx = 2'h1; // [RULE2]
						XRS_PROTO_EXT: s_next.bidx = 2'h2; // [RULE3]
						default: s_next.bidx = 2'h0; // [RULE21]
					endcase
					// known protocol: one burst; unknown: all three in turn
					s_next.blast = (pwdata[5:4] == 2'h3) ? 2'h2 : s_next.bidx;
				end
				OP_RESCUE:
				begin
					s_next.st = ST_BURST;
					s_next.cs_n = 1'b0;
					s_next.drive = 1'b1;
					s_next.bidx = 2'h0; // [RULE11]
					s_next.blast = 2'h3; // [RULE12]
				end
				OP_RESET_PIN:
				begin
					s_next.st = ST_RLOW;
					s_next.rst_n = 1'b0; // [RULE5]
				end
				OP_POWER_WAIT:
				begin
					s_next.st = ST_PWR;
					s_next.ready = 1'b0;
				end
				default: s_next.op = 3'h0;
			endcase
		end
		unique case (s_reg.st)
			ST_IDLE:
			begin
			end
			ST_PWR:
			begin
				// device may still be rejecting commands until this expires
				if (s_reg.cnt == 32'(POWER_TO_ACCESS_CYC - 1)) // [RULE9]
				begin
					s_next.st = ST_IDLE;
					s_next.ready = 1'b1;
				end
				else
					s_next.cnt = s_reg.cnt + 32'h1;
			end
			ST_BURST:
			begin
				if (s_reg.div == 8'(HALF_PERIOD - 1))
				begin
					s_next.div = 8'h00;
					s_next.sclk = ~s_reg.sclk;
					if (!s_reg.sclk)
						s_next.ccnt = s_reg.ccnt + 6'h01;
					// lift select on the falling edge after the last clock
					else if (s_reg.ccnt == burst_len(s_reg.bidx)) // [RULE11]
					begin
						s_next.st = ST_GAP;
						s_next.cs_n = 1'b1; // [RULE1]
						s_next.cnt = 32'h0;
					end
				end
				else
					s_next.div = s_reg.div + 8'h01;
			end
			ST_GAP:
			begin
				if (s_reg.cnt >= 32'(RESCUE_DESELECT_CYC - 1)) // [RULE10]
				begin
					s_next.ccnt = 6'h00;
					s_next.div = 8'h00;
					if (s_reg.bidx == s_reg.blast)
					begin
						s_next.st = ST_IDLE;
						s_next.drive = 1'b0;
						if (s_reg.op == OP_RESCUE)
						begin
							s_next.proto = XRS_PROTO_EXT; // [RULE13]
							s_next.nv_redo = 1'b1; // [RULE14]
						end
					end
					else
					begin
						s_next.st = ST_BURST;
						s_next.cs_n = 1'b0;
						s_next.bidx = s_reg.bidx + 2'h1;
					end
				end
				else
					s_next.cnt = s_reg.cnt + 32'h1;
			end
			ST_RLOW:
			begin
				if (s_reg.cnt == 32'(RESET_PULSE_CYC - 1)) // [RULE15]
				begin
					s_next.st = ST_RWAIT;
					s_next.rst_n = 1'b1;
					s_next.cnt = 32'h0;
				end
				else
					s_next.cnt = s_reg.cnt + 32'h1;
			end
			ST_RWAIT:
			begin
				// device is back in its nonvolatile mode, which is unknown here
				if (s_reg.cnt + 32'h1 >= rec_target) // [RULE16]
				begin
					s_next.st = ST_IDLE;
					s_next.proto = XRS_PROTO_UNKNOWN;
				end
				else
					s_next.cnt = s_reg.cnt + 32'h1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_reg <= HOST_RESET;
		else
			s_reg <= s_next;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign prdata = s_reg.rdata;
	assign pready = s_reg.rdy;
	assign pslverr = s_reg.err;
	assign link.chip_select_n = s_reg.cs_n;
	assign link.serial_clock = s_reg.sclk;
	assign link.reset_input_n = s_reg.rst_n;
	// io0 and io3 both held high through every burst
	assign link.data0_out = 1'b1;
	assign link.data0_oe = s_reg.drive;
	assign link.data3_out = 1'b1;
	assign link.data3_oe = s_reg.drive;

endmodule // xrs_host

// [xrs_pkg.sv]
// shared constants and types for the xip exit and rescue sequencer pair
package xrs_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int RESCUE_DESELECT_NS = 50;
	localparam int RESET_PULSE_WIDTH_NS = 50;
	localparam int RESET_RECOVERY_NS = 40;
	localparam int ARRAY_RECOVERY_US = 30;
	localparam int POWER_TO_READ_US = 150;
	localparam int POWER_TO_ACCESS_US = 150;
	// least times round up, longest times round down, never below one cycle
	localparam int RESCUE_DESELECT_CYC = (RESCUE_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_RECOVERY_CYC = (RESET_RECOVERY_NS / CLK_PERIOD_NS < 1) ? 1
		: RESET_RECOVERY_NS / CLK_PERIOD_NS;
	localparam int ARRAY_RECOVERY_CYC = ARRAY_RECOVERY_US * 1000 / CLK_PERIOD_NS;
	localparam int POWER_TO_READ_CYC = POWER_TO_READ_US * 1000 / CLK_PERIOD_NS;
	localparam int POWER_TO_ACCESS_CYC = POWER_TO_ACCESS_US * 1000 / CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYC = 4;

	// ************************************************************
	// burst lengths
	// ************************************************************
	localparam logic [5:0] BURST_QUAD = 6'h07;
	localparam logic [5:0] BURST_DUAL = 6'h0d;
	localparam logic [5:0] BURST_EXT = 6'h19;
	localparam logic [5:0] BURST_ALL_ONES = 6'h08;

	// ************************************************************
	// protocols, commands, register map
	// ************************************************************
	typedef enum logic [1:0] {
		XRS_PROTO_EXT = 2'h0,
		XRS_PROTO_DUAL = 2'h1,
		XRS_PROTO_QUAD = 2'h2,
		XRS_PROTO_UNKNOWN = 2'h3
	} xrs_proto_t;

	localparam logic [7:0] CMD_READ_STATUS = 8'h05;
	localparam logic [7:0] CMD_READ_FLAG_STATUS = 8'h70;

	localparam logic [2:0] OP_EXIT_XIP = 3'h1;
	localparam logic [2:0] OP_RESCUE = 3'h2;
	localparam logic [2:0] OP_RESET_PIN = 3'h3;
	localparam logic [2:0] OP_POWER_WAIT = 3'h4;

	localparam logic [1:0] REC_SHORT = 2'h0;
	localparam logic [1:0] REC_ARRAY = 2'h1;
	localparam logic [1:0] REC_LONG = 2'h2;

	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] LONG_WAIT_OFFSET = 8'h08;
	localparam logic [31:0] LONG_WAIT_RESET = 32'h0000_0001;

	// first dummy clock of an xip read: address clocks plus one
	function automatic logic [5:0] xip_sample_clk(input xrs_proto_t p);
		case (p)
			XRS_PROTO_QUAD: xip_sample_clk = BURST_QUAD;
			XRS_PROTO_DUAL: xip_sample_clk = BURST_DUAL;
			default: xip_sample_clk = BURST_EXT;
		endcase
	endfunction

	// burst list: index 0..3 gives 7, 13, 25, then the all-ones byte
	function automatic logic [5:0] burst_len(input logic [1:0] idx);
		case (idx)
			2'h0: burst_len = BURST_QUAD;
			2'h1: burst_len = BURST_DUAL;
			2'h2: burst_len = BURST_EXT;
			default: burst_len = BURST_ALL_ONES;
		endcase
	endfunction

endpackage

// [xrs_link_if.sv]
// link between the flash controller end and the flash device end
`timescale 1ns/10ps
interface xrs_link_if;
	logic chip_select_n;
	logic serial_clock;
	logic reset_input_n;
	logic data0_out;
	logic data0_oe;
	logic data3_out;
	logic data3_oe;
	wire logic serial_data_io0;
	wire logic hold_data_io3;

	// pull-ups hold both lines high while nobody drives them
	assign serial_data_io0 = data0_oe ? data0_out : 1'b1;
	assign hold_data_io3 = data3_oe ? data3_out : 1'b1;

	modport host (
		output chip_select_n,
		output serial_clock,
		output reset_input_n,
		output data0_out,
		output data0_oe,
		output data3_out,
		output data3_oe,
		input serial_data_io0,
		input hold_data_io3
	);

	modport dev (
		input chip_select_n,
		input serial_clock,
		input reset_input_n,
		input serial_data_io0,
		input hold_data_io3
	);
endinterface

// [xrs_dev.sv]
// flash device end: xip exit, rescue, power-on and reset-pin behaviour
`timescale 1ns/10ps
module xrs_dev
	import xrs_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWER_TO_ACCESS_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	xrs_link_if.dev link,
	input wire logic power_good,
	input wire xrs_pkg::xrs_proto_t nv_protocol,
	input wire logic nv_xip_en,
	input wire logic array_busy,
	input wire logic wel_set,
	input wire logic wel_clr,
	input wire logic [1:0] lock_set,
	output xrs_pkg::xrs_proto_t protocol,
	output logic xip_active,
	output logic xip_confirm,
	output logic vcr_xip_bit,
	output logic powerup_phase,
	output logic write_enable_latch,
	output logic write_in_progress,
	output logic [1:0] lock_bits,
	output logic cmd_accept,
	output logic cmd_reject,
	output logic [7:0] cmd_code
);
	import xrs_pkg::*;

	typedef struct packed {
		logic [1:0] cs_s;
		logic [1:0] ck_s;
		logic [1:0] d0_s;
		logic [1:0] d3_s;
		logic [1:0] rst_s;
		logic [1:0] pg_s;
		logic ck_d;
		logic cs_d;
		logic [5:0] clk_cnt;
		logic ones0;
		logic ones3;
		logic [7:0] shift;
		logic [1:0] resc_step;
		xrs_proto_t proto;
		logic xip;
		logic confirm;
		logic vcr_bit;
		logic pu_phase;
		logic [11:0] pu_cnt;
		logic wel;
		logic wip;
		logic [1:0] lock;
		logic acc;
		logic rej;
		logic [7:0] code;
	} xrs_dev_state_t;

	localparam xrs_dev_state_t DEV_RESET = '{cs_s: 2'h3, ck_s: 2'h0, d0_s: 2'h3, d3_s: 2'h3,
		rst_s: 2'h3, pg_s: 2'h0, ck_d: 1'b0, cs_d: 1'b1, clk_cnt: 6'h00, ones0: 1'b1,
		ones3: 1'b1, shift: 8'h00, resc_step: 2'h0, proto: XRS_PROTO_EXT, xip: 1'b0,
		confirm: 1'b1, vcr_bit: 1'b1, pu_phase: 1'b1, pu_cnt: 12'h000, wel: 1'b0,
		wip: 1'b0, lock: 2'h0, acc: 1'b0, rej: 1'b0, code: 8'h00};

	xrs_dev_state_t s_reg;
	xrs_dev_state_t s_next;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		s_next = s_reg;
		// two flops on every pin before anything looks at it
		s_next.cs_s = {s_reg.cs_s[0], link.chip_select_n};
		s_next.ck_s = {s_reg.ck_s[0], link.serial_clock};
		s_next.d0_s = {s_reg.d0_s[0], link.serial_data_io0};
		s_next.d3_s = {s_reg.d3_s[0], link.hold_data_io3};
		s_next.rst_s = {s_reg.rst_s[0], link.reset_input_n};
		s_next.pg_s = {s_reg.pg_s[0], power_good};
		s_next.ck_d = s_reg.ck_s[1];
		s_next.cs_d = s_reg.cs_s[1];
		s_next.acc = 1'b0;
		s_next.rej = 1'b0;
		if (!s_reg.pg_s[1] || !s_reg.rst_s[1])
		begin
			// power-on or pin reset: back to the nonvolatile start-up state
			s_next.proto = nv_protocol; // [RULE5]
			s_next.xip = nv_xip_en;
			s_next.confirm = ~nv_xip_en;
			s_next.vcr_bit = ~nv_xip_en;
			s_next.clk_cnt = 6'h00;
			s_next.resc_step = 2'h0;
			s_next.wel = 1'b0; // [RULE8]
			if (!s_reg.pg_s[1])
			begin
				// below threshold: logic held, every instruction ignored
				s_next.pu_phase = 1'b1; // [RULE6]
				s_next.pu_cnt = 12'h000;
				s_next.wip = 1'b0; // [RULE8]
				s_next.lock = 2'h0; // [RULE8]
			end
		end
		else
		begin
			if (s_reg.pu_phase)
			begin
				if (s_reg.pu_cnt == 12'(POWERUP_CYCLES - 1))
					s_next.pu_phase = 1'b0;
				else
					s_next.pu_cnt = s_reg.pu_cnt + 12'h001;
			end
			// program or erase keeps running through an xip exit
			s_next.wip = array_busy; // [RULE4]
			if (wel_set)
				s_next.wel = 1'b1;
			else if (wel_clr)
				s_next.wel = 1'b0;
			s_next.lock = s_reg.lock | lock_set;
			if (!s_reg.cs_s[1] && s_reg.ck_s[1] && !s_reg.ck_d)
			begin
				if (s_reg.clk_cnt != 6'h3f)
					s_next.clk_cnt = s_reg.clk_cnt + 6'h01;
				s_next.ones0 = s_reg.ones0 & s_reg.d0_s[1];
				s_next.ones3 = s_reg.ones3 & s_reg.d3_s[1];
				s_next.shift = {s_reg.shift[6:0], s_reg.d0_s[1]};
				// confirmation bit sits in the first dummy clock
				if (s_reg.xip && s_next.clk_cnt == xip_sample_clk(s_reg.proto)) // [RULE19]
				begin
					s_next.confirm = s_reg.d0_s[1]; // [RULE19]
					if (s_reg.d0_s[1])
					begin
						s_next.xip = 1'b0; // [RULE4]
						s_next.vcr_bit = 1'b1; // [RULE20]
					end
				end
				// opcode check only outside xip, where a command code is sent
				if (!s_reg.xip && s_next.clk_cnt == BURST_ALL_ONES)
				begin
					s_next.code = {s_reg.shift[6:0], s_reg.d0_s[1]};
					if (s_reg.pu_phase && s_next.code != CMD_READ_STATUS
						&& s_next.code != CMD_READ_FLAG_STATUS)
						s_next.rej = 1'b1; // [RULE7]
					else
						s_next.acc = 1'b1; // [RULE7]
				end
			end
			if (s_reg.cs_s[1] && !s_reg.cs_d)
			begin
				// frame ended: advance the two-part rescue tracker
				s_next.clk_cnt = 6'h00;
				s_next.ones0 = 1'b1;
				s_next.ones3 = 1'b1;
				s_next.resc_step = 2'h0;
				if (s_reg.ones0 && s_reg.ones3)
				begin
					if (s_reg.clk_cnt == BURST_QUAD)
						s_next.resc_step = 2'h1;
					else if (s_reg.clk_cnt == BURST_DUAL && s_reg.resc_step == 2'h1)
						s_next.resc_step = 2'h2;
					else if (s_reg.clk_cnt == BURST_EXT && s_reg.resc_step == 2'h2)
						s_next.resc_step = 2'h3;
					else if (s_reg.clk_cnt == BURST_ALL_ONES && s_reg.resc_step == 2'h3)
					begin
						s_next.proto = XRS_PROTO_EXT; // [RULE13]
						s_next.xip = 1'b0; // [RULE13]
						s_next.confirm = 1'b1;
						s_next.vcr_bit = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_reg <= DEV_RESET;
		else
			s_reg <= s_next;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign protocol = s_reg.proto;
	assign xip_active = s_reg.xip;
	assign xip_confirm = s_reg.confirm;
	assign vcr_xip_bit = s_reg.vcr_bit;
	assign powerup_phase = s_reg.pu_phase;
	assign write_enable_latch = s_reg.wel;
	assign write_in_progress = s_reg.wip;
	assign lock_bits = s_reg.lock;
	assign cmd_accept = s_reg.acc;
	assign cmd_reject = s_reg.rej;
	assign cmd_code = s_reg.code;

endmodule // xrs_dev

// [xrs_link_chk.sv]
// checker for the link between the controller end and the device end
`timescale 1ns/10ps
module xrs_link_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic chip_select_n,
	input wire logic serial_clock,
	input wire logic reset_input_n,
	input wire logic serial_data_io0,
	input wire logic hold_data_io3
);
	// ********************
	// frame counting
	// ********************
	logic sclk_q;
	logic cs_q;
	logic [5:0] cnt;
	logic [5:0] last_len;
	logic frame_end;
	assign frame_end = chip_select_n && !cs_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			cnt <= 6'h00;
			last_len <= 6'h00;
		end
		else
		begin
			sclk_q <= serial_clock;
			cs_q <= chip_select_n;
			if (chip_select_n)
				cnt <= 6'h00;
			else if (serial_clock && !sclk_q)
				cnt <= cnt + 6'h01;
			if (frame_end)
				last_len <= cnt;
		end
	end
	// ********************
	// properties
	// ********************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_io0_high;
		!chip_select_n |-> serial_data_io0;
	endproperty
	a_io0_high: assert property (p_io0_high) else $error("io0 low in frame");
	property p_io3_high;
		!chip_select_n |-> hold_data_io3;
	endproperty
	a_io3_high: assert property (p_io3_high) else $error("io3 low in frame");
	property p_burst_len;
		frame_end |-> (cnt == 6'h07) || (cnt == 6'h0d) || (cnt == 6'h19) || (cnt == 6'h08);
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("bad burst length");
	property p_ones_order;
		frame_end && cnt == 6'h08 |-> last_len == 6'h19;
	endproperty
	a_ones_order: assert property (p_ones_order) else $error("ones byte out of order");
	property p_deselect;
		$rose(chip_select_n) |-> chip_select_n [*2];
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselect too short");
	property p_sclk_idle;
		chip_select_n |-> !serial_clock;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("clock while deselected");
	property p_burst_bound;
		$fell(chip_select_n) |-> ##[1:260] chip_select_n;
	endproperty
	a_burst_bound: assert property (p_burst_bound) else $error("frame too long");
	property p_rst_width;
		$fell(reset_input_n) |-> !reset_input_n [*2];
	endproperty
	a_rst_width: assert property (p_rst_width) else $error("reset pulse short");
	property p_rst_desel;
		!reset_input_n |-> chip_select_n;
	endproperty
	a_rst_desel: assert property (p_rst_desel) else $error("selected in reset");
	property p_rst_recover;
		$rose(reset_input_n) |-> chip_select_n [*2];
	endproperty
	a_rst_recover: assert property (p_rst_recover) else $error("select after reset");
	c_ones: cover property (frame_end && cnt == 6'h08);
	c_dual: cover property (frame_end && cnt == 6'h0d);
	c_rst: cover property ($fell(reset_input_n));
endmodule // xrs_link_chk

// [test_xip_exit_rescue_sequencer.sv]
// self-checking bench for the xip exit and rescue sequencer pair
`timescale 1ns/10ps
module test_xip_exit_rescue_sequencer;
	import xrs_pkg::*;
	// ********************
	// signals and ends
	// ********************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_q;
	logic pready, pslverr, rd_e;
	logic pg = 1'b0, pg2 = 1'b0, nvx = 1'b1, busy_in = 1'b0, wel_s = 1'b0, wel_c = 1'b0;
	logic [1:0] lock_s = 2'h0;
	xrs_proto_t nvp = XRS_PROTO_QUAD;
	xrs_proto_t proto;
	logic xip, conf, vcr, pup, wel, wip, pup2, wel2, wip2, acc2, rej2, xip2, conf2;
	logic nvx2 = 1'b0;
	logic [1:0] lock, lock2;
	logic [7:0] code2;
	int err_total = 0;
	int compares = 0;
	int acc_n = 0;
	int rej_n = 0;
	int nrise = 0;
	time t0;
	logic sq = 1'b0;
	logic [5:0] bursts[$];
	xrs_link_if link();
	xrs_link_if link2();
	always #20 pclk = ~pclk;
	xrs_host #(.HALF_PERIOD(SCLK_HALF_CYC)) xrs_host_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
	xrs_dev #(.POWERUP_CYCLES(20)) xrs_dev_i (.pclk(pclk), .presetn(presetn), .link(link.dev),
		.power_good(pg), .nv_protocol(nvp), .nv_xip_en(nvx), .array_busy(busy_in),
		.wel_set(wel_s), .wel_clr(wel_c), .lock_set(lock_s), .protocol(proto), .xip_active(xip),
		.xip_confirm(conf), .vcr_xip_bit(vcr), .powerup_phase(pup), .write_enable_latch(wel),
		.write_in_progress(wip), .lock_bits(lock), .cmd_accept(), .cmd_reject(), .cmd_code());
	// second device, driven by the bench directly to probe power-up command filtering
	xrs_dev #(.POWERUP_CYCLES(2000)) xrs_dev2_i (.pclk(pclk), .presetn(presetn),
		.link(link2.dev), .power_good(pg2), .nv_protocol(nvp), .nv_xip_en(nvx2),
		.array_busy(busy_in), .wel_set(wel_s), .wel_clr(wel_c), .lock_set(lock_s), .protocol(),
		.xip_active(xip2), .xip_confirm(conf2), .vcr_xip_bit(), .powerup_phase(pup2),
		.write_enable_latch(wel2), .write_in_progress(wip2), .lock_bits(lock2),
		.cmd_accept(acc2), .cmd_reject(rej2), .cmd_code(code2));
	xrs_link_chk xrs_link_chk_i (.pclk(pclk), .presetn(presetn),
		.chip_select_n(link.chip_select_n), .serial_clock(link.serial_clock),
		.reset_input_n(link.reset_input_n), .serial_data_io0(link.serial_data_io0),
		.hold_data_io3(link.hold_data_io3));
	always @(posedge pclk)
	begin
		sq <= link.serial_clock;
		if (!link.chip_select_n && link.serial_clock && !sq)
			nrise <= nrise + 1;
		if (link.chip_select_n && nrise != 0)
		begin
			bursts.push_back(nrise[5:0]);
			nrise <= 0;
		end
		if (acc2 === 1'b1)
			acc_n <= acc_n + 1;
		if (rej2 === 1'b1)
			rej_n <= rej_n + 1;
	end
	// ********************
	// shared tasks
	// ********************
	task automatic close_out;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic give_up;
		err_total++;
		close_out();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		rd_q = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			give_up();
	endtask
	task automatic run_op(input logic [2:0] op, input logic [1:0] pr, input logic [1:0] rc);
		int n;
		bursts.delete();
		apb(1'b1, CTRL_OFFSET, {24'h0, rc, pr, 1'b0, op});
		n = 0;
		do
		begin
			apb(1'b0, STATUS_OFFSET, 32'h0);
			n++;
		end
		while (rd_q[0] !== 1'b0 && n < 3000);
		if (rd_q[0] !== 1'b0)
			give_up();
	endtask
	task automatic chk_bursts(input logic [23:0] exp, input int n);
		chk(bursts.size(), n);
		for (int i = 0; i < n && i < bursts.size(); i++)
			chk({26'h0, bursts[i]}, {26'h0, exp[23-6*i -: 6]});
	endtask
	task automatic send2(input logic [7:0] c);
		@(posedge pclk);
		link2.chip_select_n <= 1'b0;
		link2.data0_oe <= 1'b1;
		for (int i = 7; i >= 0; i--)
		begin
			link2.data0_out <= c[i];
			repeat (4) @(posedge pclk);
			link2.serial_clock <= 1'b1;
			repeat (4) @(posedge pclk);
			link2.serial_clock <= 1'b0;
		end
		link2.chip_select_n <= 1'b1;
		// released line falls back to its pull-up
		link2.data0_oe <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
	// ********************
	// scenarios
	// ********************
	task automatic powerup_cmds;
		int n;
		send2(CMD_READ_STATUS);
		chk(acc_n + rej_n, 0);
		pg2 <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({31'h0, pup2}, 1);
		send2(8'h06);
		chk(rej_n, 1);
		send2(CMD_READ_STATUS);
		send2(CMD_READ_FLAG_STATUS);
		chk(acc_n, 2);
		chk({24'h0, code2}, {24'h0, CMD_READ_FLAG_STATUS});
		n = 0;
		while (pup2 !== 1'b0 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		if (pup2 !== 1'b0)
			give_up();
		chk({28'h0, wel2, wip2, lock2}, 0);
		send2(8'h06);
		chk(acc_n, 3);
		// power cycle into quad xip: io0 low in the first dummy clock keeps xip
		nvx2 <= 1'b1;
		pg2 <= 1'b0;
		repeat (4) @(posedge pclk);
		pg2 <= 1'b1;
		send2(8'h00);
		chk({30'h0, xip2, conf2}, 32'h2);
	endtask
	task automatic exit_case(input xrs_proto_t p, input logic [1:0] rec,
		input logic [1:0] rc, input logic [23:0] exp, input int n);
		nvp <= p;
		wel_s <= 1'b1;
		@(posedge pclk);
		wel_s <= 1'b0;
		run_op(OP_RESET_PIN, 2'h0, rc);
		chk({27'h0, wel, proto, xip, vcr}, {27'h0, 1'b0, p, 1'b1, 1'b0});
		busy_in <= 1'b1;
		run_op(OP_EXIT_XIP, rec, 2'h0);
		chk_bursts(exp, n);
		chk({28'h0, xip, conf, vcr, wip}, 32'h7);
		chk({29'h0, vcr, proto}, {29'h0, 1'b1, p});
		busy_in <= 1'b0;
	endtask
	task automatic rescue_case;
		nvp <= XRS_PROTO_QUAD;
		run_op(OP_RESET_PIN, 2'h0, 2'h0);
		run_op(OP_RESCUE, 2'h2, 2'h0);
		chk_bursts({6'h07, 6'h0d, 6'h19, 6'h08}, 4);
		chk({28'h0, proto, xip, vcr}, {28'h0, XRS_PROTO_EXT, 1'b0, 1'b1});
		apb(1'b0, STATUS_OFFSET, 32'h0);
		chk({31'h0, rd_q[2]}, 1);
		apb(1'b1, STATUS_OFFSET, 32'h4);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		chk({31'h0, rd_q[2]}, 0);
	endtask
	initial
	begin
		link2.chip_select_n = 1'b1;
		link2.serial_clock = 1'b0;
		link2.reset_input_n = 1'b1;
		link2.data0_out = 1'b1;
		link2.data0_oe = 1'b0;
		link2.data3_out = 1'b1;
		link2.data3_oe = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		powerup_cmds();
		pg <= 1'b1;
		repeat (40) @(posedge pclk);
		chk({27'h0, pup, wel, wip, lock}, 0);
		chk({30'h0, proto}, {30'h0, XRS_PROTO_QUAD});
		apb(1'b0, LONG_WAIT_OFFSET, 32'h0);
		chk(rd_q, LONG_WAIT_RESET);
		apb(1'b0, 8'h0c, 32'h0);
		chk({31'h0, rd_e}, 1);
		apb(1'b1, LONG_WAIT_OFFSET, 32'h5);
		apb(1'b0, LONG_WAIT_OFFSET, 32'h0);
		chk(rd_q, 32'h5);
		exit_case(XRS_PROTO_QUAD, 2'h2, 2'h0, {6'h07, 18'h0}, 1);
		exit_case(XRS_PROTO_DUAL, 2'h1, 2'h1, {6'h0d, 18'h0}, 1);
		exit_case(XRS_PROTO_EXT, 2'h0, 2'h2, {6'h19, 18'h0}, 1);
		exit_case(XRS_PROTO_EXT, 2'h3, 2'h0, {6'h07, 6'h0d, 6'h19, 6'h00}, 3);
		rescue_case();
		t0 = $time;
		run_op(OP_POWER_WAIT, 2'h0, 2'h0);
		// the wait must not end before the full access delay
		chk({31'h0, $time - t0 >= POWER_TO_ACCESS_CYC * CLK_PERIOD_NS}, 1);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		chk({31'h0, rd_q[1]}, 1);
		close_out();
	end
endmodule // test_xip_exit_rescue_sequencer
